//--- common/usp_pkg.sv
package usp_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA   = 8'h88;
    localparam logic [7:0] ADDR_STATUS = 8'h8C;
    localparam logic [7:0] ADDR_ENABLE = 8'h90;
    localparam logic [7:0] ADDR_MODE   = 8'h94;
    localparam logic [7:0] ADDR_BAUD   = 8'h98;

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int STAT_RXC_POS  = 7;
    localparam int STAT_TXC_POS  = 6;
    localparam int STAT_UDRE_POS = 5;

    localparam logic [1:0] MODE_SEL_SPI = 2'h3;

    // ----------------------------------------------------------------
    // reset values, bus answers and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_ENABLE = 8'h00;
    localparam logic [7:0]  RST_MODE   = 8'h00;
    localparam logic        RST_UDRE   = 1'h1;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int          FRAME_EDGES = 16;
    localparam int          RX_DEPTH    = 2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic { ST_IDLE, ST_SHIFT } usp_state_e;

    typedef struct packed {
        logic rx_complete_irq_enable;
        logic transmit_complete_irq_enable;
        logic buffer_empty_irq_enable;
        logic receiver_enable;
        logic transmitter_enable;
    } usp_enable_s;

    typedef struct packed {
        logic [1:0] mode_select_field;
        logic       data_order_bit;
        logic       clock_phase_bit;
        logic       clock_polarity_bit;
    } usp_mode_s;

endpackage

//--- verilog/usp_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1 - receive flag high while buffer holds data
// RL2 - disabling receiver flushes receive buffer
// RL3 - transmit flag set when frame and buffer done
// RL4 - transmit flag cleared by service or one-write
// RL5 - empty flag when buffer free, set at reset
// RL6 - receive irq needs enable, global, flag
// RL7 - transmit irq needs enable, global, flag
// RL8 - empty irq needs enable, global, flag
// RL9 - receiver enable takes over data-in pin
// RL10 - receiver alone never starts a transfer
// RL11 - transmitter enable takes over data-out pin
// RL12 - transmitter disable waits for pending data
// RL13 - stopped transmitter releases data-out pin
// RL14 - mode field 11 selects master spi
// RL15 - format bits apply in same write
// RL16 - order bit one sends lsb first
// RL17 - phase bit picks sampling edge
// RL18 - polarity bit sets idle clock level
// RL19 - software writes zeros to reserved bits
// RL20 - data register write starts each transfer
// RL21 - error flags read as zero
// RL22 - overflow drops newest byte, keeps older
module usp_top #(
    parameter int BAUD_W = 12
) (
    // clock and reset
    input  wire logic              CLOCK_I,
    input  wire logic              ARST_N_I,
    // axi4-lite write
    input  wire logic              S_AXI_AWVALID_I,
    input  wire logic [7:0]        S_AXI_AWADDR_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic              S_AXI_WVALID_I,
    input  wire logic [31:0]       S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    output logic                   S_AXI_WREADY_O,
    output logic                   S_AXI_BVALID_O,
    output logic [1:0]             S_AXI_BRESP_O,
    input  wire logic              S_AXI_BREADY_I,
    // axi4-lite read
    input  wire logic              S_AXI_ARVALID_I,
    input  wire logic [7:0]        S_AXI_ARADDR_I,
    output logic                   S_AXI_ARREADY_O,
    output logic                   S_AXI_RVALID_O,
    output logic [31:0]            S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    input  wire logic              S_AXI_RREADY_I,
    // serial pins
    output logic                   TRANSFER_CLOCK_O,
    output logic                   TRANSFER_CLOCK_OE_O,
    output logic                   SERIAL_DATA_OUT_O,
    output logic                   SERIAL_DATA_OUT_OE_O,
    input  wire logic              SERIAL_DATA_IN_I,
    output logic                   SERIAL_DATA_IN_OVR_O,
    // interrupt requests
    input  wire logic              GLOBAL_IRQ_FLAG_I,
    input  wire logic              TX_COMPLETE_IRQ_ACK_I,
    output logic                   RX_COMPLETE_IRQ_O,
    output logic                   TX_COMPLETE_IRQ_O,
    output logic                   BUFFER_EMPTY_IRQ_O
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    usp_pkg::usp_enable_s  enable_ff;
    usp_pkg::usp_mode_s    mode_ff;
    usp_pkg::usp_state_e   state_ff;
    logic [BAUD_W-1:0]     baud_ff;
    logic [BAUD_W-1:0]     div_cnt_ff;
    logic [3:0]            edge_cnt_ff;
    logic [7:0]            tx_buf_ff;
    logic                  tx_buf_full_ff;
    logic [7:0]            tx_sh_ff;
    logic [7:0]            rx_sh_ff;
    logic [7:0]            rx_mem_ff [usp_pkg::RX_DEPTH];
    logic [1:0]            rx_cnt_ff;
    logic                  txc_ff;
    logic                  tx_active_ff;
    logic                  sck_ff;
    logic                  mosi_ff;
    logic                  din_meta_ff;
    logic                  din_ff;
    logic                  aw_full_ff;
    logic                  w_full_ff;
    logic [7:0]            aw_addr_ff;
    logic [7:0]            w_data_ff;
    logic                  w_lane0_ff;
    logic                  awready_ff;
    logic                  wready_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  arready_ff;
    logic                  rvalid_ff;
    logic [31:0]           rdata_ff;
    logic [1:0]            rresp_ff;
    logic                  rx_irq_ff;
    logic                  tx_irq_ff;
    logic                  ud_irq_ff;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == usp_pkg::ADDR_DATA)   ||
                     (a == usp_pkg::ADDR_STATUS) ||
                     (a == usp_pkg::ADDR_ENABLE) ||
                     (a == usp_pkg::ADDR_MODE)   ||
                     (a == usp_pkg::ADDR_BAUD);
    endfunction

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire aw_hs    = S_AXI_AWVALID_I & awready_ff;
    wire w_hs     = S_AXI_WVALID_I & wready_ff;
    wire ar_hs    = S_AXI_ARVALID_I & arready_ff;
    wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire wr_en    = do_write & w_lane0_ff;
    wire wr_data  = wr_en & (aw_addr_ff == usp_pkg::ADDR_DATA);
    wire wr_stat  = wr_en & (aw_addr_ff == usp_pkg::ADDR_STATUS);
    wire wr_enab  = wr_en & (aw_addr_ff == usp_pkg::ADDR_ENABLE);
    wire wr_mode  = wr_en & (aw_addr_ff == usp_pkg::ADDR_MODE);
    wire wr_baud  = wr_en & (aw_addr_ff == usp_pkg::ADDR_BAUD);
    wire rd_pop   = ar_hs & (S_AXI_ARADDR_I == usp_pkg::ADDR_DATA)
                    & (rx_cnt_ff != 2'h0);

    wire nxt_aw_full = (aw_full_ff | aw_hs) & ~do_write;
    wire nxt_w_full  = (w_full_ff | w_hs) & ~do_write;
    wire nxt_bvalid  = do_write | (bvalid_ff & ~S_AXI_BREADY_I);
    wire nxt_rvalid  = ar_hs | (rvalid_ff & ~S_AXI_RREADY_I);

    // ----------------------------------------------------------------
    // status view and read mux
    // ----------------------------------------------------------------
    wire       rxc_flag  = (rx_cnt_ff != 2'h0); // RL1
    wire       udre_flag = ~tx_buf_full_ff; // RL5
    // error flags and reserved bits stay zero
    wire [7:0] status_rd = {rxc_flag, txc_ff, udre_flag, 5'h00}; // RL21
    wire [7:0] enable_rd = {enable_ff, 3'h0};
    wire [7:0] mode_rd   = {mode_ff.mode_select_field, 3'h0,
                            mode_ff.data_order_bit,
                            mode_ff.clock_phase_bit,
                            mode_ff.clock_polarity_bit};
    wire [31:0] rd_mux =
        (S_AXI_ARADDR_I == usp_pkg::ADDR_DATA)   ? {24'h0, rx_mem_ff[0]} :
        (S_AXI_ARADDR_I == usp_pkg::ADDR_STATUS) ? {24'h0, status_rd}    :
        (S_AXI_ARADDR_I == usp_pkg::ADDR_ENABLE) ? {24'h0, enable_rd}    :
        (S_AXI_ARADDR_I == usp_pkg::ADDR_MODE)   ? {24'h0, mode_rd}      :
        (S_AXI_ARADDR_I == usp_pkg::ADDR_BAUD)
            ? {{(32-BAUD_W){1'b0}}, baud_ff} : 32'h0;

    // ----------------------------------------------------------------
    // shift engine decode
    // ----------------------------------------------------------------
    wire spi_on    = (mode_ff.mode_select_field == usp_pkg::MODE_SEL_SPI); // RL14
    wire tick      = (state_ff == usp_pkg::ST_SHIFT) & (div_cnt_ff == baud_ff);
    wire leading   = ~edge_cnt_ff[0];
    // phase 0 samples leading edges, phase 1 trailing edges
    wire sample_ev = tick & (leading ^ mode_ff.clock_phase_bit); // RL17
    wire drive_ev  = tick & ~(leading ^ mode_ff.clock_phase_bit);
    wire last_edge = tick & (edge_cnt_ff == 4'(usp_pkg::FRAME_EDGES - 1));
    // the transmitter alone owns the clock, so rx enable cannot start
    wire start     = (state_ff == usp_pkg::ST_IDLE) & tx_buf_full_ff
                     & tx_active_ff & spi_on; // RL10 RL20
    wire out_bit   = mode_ff.data_order_bit ? tx_sh_ff[0] : tx_sh_ff[7]; // RL16
    wire [7:0] tx_shifted = mode_ff.data_order_bit ? {1'b0, tx_sh_ff[7:1]}
                                                   : {tx_sh_ff[6:0], 1'b0};
    wire [7:0] rx_shifted = mode_ff.data_order_bit ? {din_ff, rx_sh_ff[7:1]}
                                                   : {rx_sh_ff[6:0], din_ff};
    // phase 0 took its last bit one edge before the frame ends
    wire [7:0] rx_byte = mode_ff.clock_phase_bit ? rx_shifted : rx_sh_ff;
    wire rx_push   = last_edge & enable_ff.receiver_enable;
    wire [1:0] cnt_after_pop = rx_cnt_ff - {1'b0, rd_pop};
    wire txc_set   = last_edge & ~tx_buf_full_ff; // RL3
    wire txc_clr   = TX_COMPLETE_IRQ_ACK_I
                     | (wr_stat & w_data_ff[usp_pkg::STAT_TXC_POS]); // RL4
    wire nxt_tx_active = enable_ff.transmitter_enable
                         | (tx_active_ff & ((state_ff != usp_pkg::ST_IDLE)
                         | tx_buf_full_ff)); // RL12

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 8'h00;
            w_lane0_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= usp_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= usp_pkg::RESP_OKAY;
        end
        else
        begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_full & ~nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (aw_hs)
                aw_addr_ff <= S_AXI_AWADDR_I;
            if (w_hs)
            begin
                w_data_ff  <= S_AXI_WDATA_I[7:0];
                w_lane0_ff <= S_AXI_WSTRB_I[0];
            end
            if (do_write)
                bresp_ff <= addr_known(aw_addr_ff) ? usp_pkg::RESP_OKAY
                                                   : usp_pkg::RESP_SLVERR;
            if (ar_hs)
            begin
                rdata_ff <= rd_mux;
                rresp_ff <= addr_known(S_AXI_ARADDR_I) ? usp_pkg::RESP_OKAY
                                                       : usp_pkg::RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            enable_ff    <= usp_pkg::usp_enable_s'(usp_pkg::RST_ENABLE[7:3]);
            mode_ff      <= usp_pkg::usp_mode_s'({usp_pkg::RST_MODE[7:6],
                                                  usp_pkg::RST_MODE[2:0]});
            baud_ff      <= '0;
            txc_ff       <= 1'b0;
            tx_active_ff <= 1'b0;
        end
        else
        begin
            if (wr_enab)
                enable_ff <= usp_pkg::usp_enable_s'(w_data_ff[7:3]);
            // one write moves mode and format together
            if (wr_mode)
                mode_ff <= usp_pkg::usp_mode_s'({w_data_ff[7:6],
                                                 w_data_ff[2:0]}); // RL15 RL19
            if (wr_baud)
                baud_ff <= {{(BAUD_W-8){1'b0}}, w_data_ff};
            // a completing frame beats a clear in the same cycle
            txc_ff       <= txc_set | (txc_ff & ~txc_clr); // RL3 RL4
            tx_active_ff <= nxt_tx_active; // RL12
        end
    end

    // ----------------------------------------------------------------
    // transmit buffer and shifter
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_ff       <= usp_pkg::ST_IDLE;
            tx_buf_ff      <= 8'h00;
            tx_buf_full_ff <= ~usp_pkg::RST_UDRE; // RL5
            tx_sh_ff       <= 8'h00;
            rx_sh_ff       <= 8'h00;
            div_cnt_ff     <= '0;
            edge_cnt_ff    <= 4'h0;
            sck_ff         <= 1'b0;
            mosi_ff        <= 1'b0;
        end
        else
        begin
            // writes while the buffer is occupied are dropped
            if (wr_data & udre_flag & tx_active_ff)
            begin
                tx_buf_ff      <= w_data_ff; // RL20
                tx_buf_full_ff <= 1'b1;
            end
            else if (start)
                tx_buf_full_ff <= 1'b0;
            if (start)
            begin
                state_ff    <= usp_pkg::ST_SHIFT;
                div_cnt_ff  <= '0;
                edge_cnt_ff <= 4'h0;
                tx_sh_ff    <= tx_buf_ff;
                if (!mode_ff.clock_phase_bit)
                begin
                    mosi_ff  <= mode_ff.data_order_bit ? tx_buf_ff[0]
                                                       : tx_buf_ff[7];
                    tx_sh_ff <= mode_ff.data_order_bit
                                ? {1'b0, tx_buf_ff[7:1]}
                                : {tx_buf_ff[6:0], 1'b0};
                end
            end
            else if (state_ff == usp_pkg::ST_SHIFT)
            begin
                div_cnt_ff <= tick ? '0 : div_cnt_ff + 1'b1;
                if (tick)
                begin
                    sck_ff      <= ~sck_ff;
                    edge_cnt_ff <= edge_cnt_ff + 4'h1;
                end
                if (drive_ev)
                begin
                    mosi_ff  <= out_bit;
                    tx_sh_ff <= tx_shifted;
                end
                if (sample_ev)
                    rx_sh_ff <= rx_shifted;
                if (last_edge)
                    state_ff <= usp_pkg::ST_IDLE;
            end
            else
                sck_ff <= mode_ff.clock_polarity_bit; // RL18
        end
    end

    // ----------------------------------------------------------------
    // receive buffer, two levels
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rx_cnt_ff    <= 2'h0;
            rx_mem_ff[0] <= 8'h00;
            rx_mem_ff[1] <= 8'h00;
            din_meta_ff  <= 1'b0;
            din_ff       <= 1'b0;
        end
        else
        begin
            din_meta_ff <= SERIAL_DATA_IN_I;
            din_ff      <= din_meta_ff;
            if (!enable_ff.receiver_enable)
                rx_cnt_ff <= 2'h0; // RL2
            else
            begin
                if (rd_pop)
                    rx_mem_ff[0] <= rx_mem_ff[1];
                // full buffer: newest byte is lost, older ones stay
                if (rx_push && cnt_after_pop != 2'(usp_pkg::RX_DEPTH))
                begin
                    rx_mem_ff[cnt_after_pop[0]] <= rx_byte; // RL22
                    rx_cnt_ff <= cnt_after_pop + 2'h1;
                end
                else
                    rx_cnt_ff <= cnt_after_pop; // RL1
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt requests
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rx_irq_ff <= 1'b0;
            tx_irq_ff <= 1'b0;
            ud_irq_ff <= 1'b0;
        end
        else
        begin
            rx_irq_ff <= enable_ff.rx_complete_irq_enable
                         & GLOBAL_IRQ_FLAG_I & rxc_flag; // RL6
            tx_irq_ff <= enable_ff.transmit_complete_irq_enable
                         & GLOBAL_IRQ_FLAG_I & txc_ff; // RL7
            ud_irq_ff <= enable_ff.buffer_empty_irq_enable
                         & GLOBAL_IRQ_FLAG_I & udre_flag; // RL8
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign S_AXI_AWREADY_O      = awready_ff;
    assign S_AXI_WREADY_O       = wready_ff;
    assign S_AXI_BVALID_O       = bvalid_ff;
    assign S_AXI_BRESP_O        = bresp_ff;
    assign S_AXI_ARREADY_O      = arready_ff;
    assign S_AXI_RVALID_O       = rvalid_ff;
    assign S_AXI_RDATA_O        = rdata_ff;
    assign S_AXI_RRESP_O        = rresp_ff;
    assign TRANSFER_CLOCK_O     = sck_ff;
    assign TRANSFER_CLOCK_OE_O  = tx_active_ff;
    assign SERIAL_DATA_OUT_O    = mosi_ff;
    assign SERIAL_DATA_OUT_OE_O = tx_active_ff; // RL11 RL13
    assign SERIAL_DATA_IN_OVR_O = enable_ff.receiver_enable; // RL9
    assign RX_COMPLETE_IRQ_O    = rx_irq_ff;
    assign TX_COMPLETE_IRQ_O    = tx_irq_ff;
    assign BUFFER_EMPTY_IRQ_O   = ud_irq_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!ARST_N_I);

    AST_RX_FLAG: assert property ( // RL1
        rx_push && rx_cnt_ff == 2'h0 && !rd_pop |=> status_rd[7])
        else $error("receive flag not set after byte arrived");
    AST_RX_FLUSH: assert property ( // RL2
        !enable_ff.receiver_enable |=> rx_cnt_ff == 2'h0 && !status_rd[7])
        else $error("receive buffer not flushed");
    AST_TXC_SET: assert property ( // RL3
        last_edge && !tx_buf_full_ff |=> txc_ff)
        else $error("transmit complete not set");
    AST_TXC_CLR: assert property ( // RL4
        txc_ff && TX_COMPLETE_IRQ_ACK_I && !last_edge |=> !txc_ff)
        else $error("transmit complete not cleared");
    AST_UDRE: assert property ( // RL5
        wr_data && udre_flag && tx_active_ff |=> !status_rd[5] ##1 1'b1)
        else $error("empty flag stayed after buffer write");
    AST_RX_IRQ: assert property ( // RL6
        RX_COMPLETE_IRQ_O |-> $past(GLOBAL_IRQ_FLAG_I) && $past(rxc_flag))
        else $error("receive irq without cause");
    AST_TX_IRQ: assert property ( // RL7
        TX_COMPLETE_IRQ_O |-> $past(GLOBAL_IRQ_FLAG_I) && $past(txc_ff))
        else $error("transmit irq without cause");
    AST_UD_IRQ: assert property ( // RL8
        BUFFER_EMPTY_IRQ_O |-> $past(GLOBAL_IRQ_FLAG_I) && $past(udre_flag))
        else $error("empty irq without cause");
    AST_NO_XFER: assert property ( // RL10
        state_ff == usp_pkg::ST_IDLE && !tx_active_ff
        |=> state_ff == usp_pkg::ST_IDLE)
        else $error("transfer without transmitter");
    AST_TX_HOLD: assert property ( // RL12
        state_ff == usp_pkg::ST_SHIFT |=> SERIAL_DATA_OUT_OE_O)
        else $error("data-out released during frame");
    AST_SPI_ONLY: assert property ( // RL14
        $rose(state_ff == usp_pkg::ST_SHIFT) |-> $past(spi_on))
        else $error("frame outside master spi mode");
    AST_IDLE_POL: assert property ( // RL18
        state_ff == usp_pkg::ST_IDLE && !start
        ##1 state_ff == usp_pkg::ST_IDLE |-> sck_ff == $past(mode_ff.clock_polarity_bit))
        else $error("idle clock level wrong");
    AST_OVERFLOW: assert property ( // RL22
        rx_cnt_ff == 2'h2 && !rd_pop && enable_ff.receiver_enable
        |=> $stable(rx_mem_ff[0]) && $stable(rx_mem_ff[1]))
        else $error("stored byte overwritten on overflow");
    AST_ERR_ZERO: assert property ( // RL21
        rvalid_ff && $past(ar_hs)
        && $past(S_AXI_ARADDR_I) == usp_pkg::ADDR_STATUS |-> rdata_ff[4:0] == 5'h00)
        else $error("error flags not zero");

    COV_FRAME: cover property (last_edge ##[1:4] txc_ff);
    COV_BACK2BACK: cover property (last_edge && tx_buf_full_ff);
    COV_OVERFLOW: cover property (rx_push && rx_cnt_ff == 2'h2 && !rd_pop);
    COV_LATE_OFF: cover property (!enable_ff.transmitter_enable && tx_active_ff);

endmodule
`default_nettype wire

//--- tb/usp_slave.sv
`timescale 1ns/1ps
`default_nettype none
module usp_slave #(
    parameter logic [7:0] REPLY = 8'hA5
) (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic [7:0]      got_o
);
    logic [7:0] tx_ff = REPLY;
    // samples on rising edges (modes 0 and 3); reply valid in mode 0 only
    always @(posedge sck_i) got_o <= {got_o[6:0], mosi_i};
    always @(negedge sck_i) tx_ff <= {tx_ff[6:0], tx_ff[7]};
    assign miso_o = tx_ff[7];
endmodule
`default_nettype wire

//--- tb/usp_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
 $display("ERROR %0t got %h want %h", $time, a, b); end end
module usp_top_bench;
localparam logic [7:0] DA=usp_pkg::ADDR_DATA, ST=usp_pkg::ADDR_STATUS;
localparam logic [7:0] EN=usp_pkg::ADDR_ENABLE, MD=usp_pkg::ADDR_MODE;
logic CLOCK_I=0, ARST_N_I=0, S_AXI_AWVALID_I=0, S_AXI_WVALID_I=0;
logic S_AXI_BREADY_I=0, S_AXI_ARVALID_I=0, S_AXI_RREADY_I=0;
logic GLOBAL_IRQ_FLAG_I=0, TX_COMPLETE_IRQ_ACK_I=0, SERIAL_DATA_IN_I;
logic [7:0] S_AXI_AWADDR_I=0, S_AXI_ARADDR_I=0, got;
logic [31:0] S_AXI_WDATA_I=0, S_AXI_RDATA_O, rd;
logic [3:0] S_AXI_WSTRB_I=4'hF;
logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, rsp;
logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
logic S_AXI_RVALID_O, TRANSFER_CLOCK_O, TRANSFER_CLOCK_OE_O;
logic SERIAL_DATA_OUT_O, SERIAL_DATA_OUT_OE_O, SERIAL_DATA_IN_OVR_O;
logic RX_COMPLETE_IRQ_O, TX_COMPLETE_IRQ_O, BUFFER_EMPTY_IRQ_O;
int err_total=0, checks_done=0, n;
usp_top dut (.*);
usp_slave peer (.sck_i(TRANSFER_CLOCK_O), .mosi_i(SERIAL_DATA_OUT_O),
    .miso_o(SERIAL_DATA_IN_I), .got_o(got));
initial forever #50 CLOCK_I = ~CLOCK_I;
task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task automatic guard;
    if (n >= 40) begin err_total++; tally_and_finish(); end
endtask
// readies are read pre-edge, so release happens on the taking edge
task automatic wr(input logic [7:0] a, d);
    @(posedge CLOCK_I);
    {S_AXI_AWADDR_I, S_AXI_WDATA_I} <= {a, 24'h0, d};
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
    n = 0;
    do begin
        @(posedge CLOCK_I);
        if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 0;
        if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 0;
        n++;
    end while (S_AXI_BVALID_O !== 1 && n < 40);
    S_AXI_BREADY_I <= 0;
    guard();
endtask
task automatic rr(input logic [7:0] a);
    @(posedge CLOCK_I);
    S_AXI_ARADDR_I <= a;
    {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'h3;
    n = 0;
    do begin
        @(posedge CLOCK_I);
        if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 0;
        n++;
    end while (S_AXI_RVALID_O !== 1 && n < 40);
    {S_AXI_RREADY_I, rd, rsp} <= {1'h0, S_AXI_RDATA_O, S_AXI_RRESP_O};
    guard();
endtask
task automatic cyc(input int k);
    repeat (k) @(posedge CLOCK_I);
endtask
task automatic wait_txc;
    for (int k = 0; k < 60; k++) begin rr(ST); #1 if (rd[6] === 1) return; end
    n = 99;
    guard();
endtask
task automatic t_reset;
    rr(ST); #1 `CHK(rd, 32'h20)
    rr(EN); #1 `CHK(rd, 32'h0)
    rr(MD); #1 `CHK(rd, 32'h0)
    rr(8'hFC); #1 `CHK(rsp, usp_pkg::RESP_SLVERR)
endtask
task automatic t_rx_only;
    wr(8'h98, 8'h03);
    wr(MD, 8'hC0);
    wr(EN, 8'h10);
    wr(DA, 8'h3C);
    cyc(80);
    `CHK(SERIAL_DATA_IN_OVR_O, 1'b1)
    `CHK(TRANSFER_CLOCK_OE_O, 1'b0)
endtask
task automatic t_frame;
    wr(EN, 8'h18);
    wr(DA, 8'h5A);
    `CHK(SERIAL_DATA_OUT_OE_O, 1'b1)
    wait_txc();
    `CHK(got, 8'h5A)
    `CHK(rd, 32'hE0)
    rr(DA); #1 `CHK(rd, 32'hA5)
    wr(ST, 8'h40);
    rr(ST); #1 `CHK(rd, 32'h20)
endtask
task automatic t_order;
    wr(MD, 8'h00);
    wr(MD, 8'hC4);
    wr(DA, 8'h01);
    wait_txc();
    `CHK(got, 8'h80)
    wr(ST, 8'h40);
    wr(MD, 8'hC3);
    wr(DA, 8'h96);
    wait_txc();
    `CHK(got, 8'h96)
    wr(MD, 8'hC0);
endtask
task automatic t_irq;
    wr(EN, 8'hF8);
    GLOBAL_IRQ_FLAG_I <= 1;
    cyc(2);
    `CHK({RX_COMPLETE_IRQ_O, TX_COMPLETE_IRQ_O, BUFFER_EMPTY_IRQ_O}, 3'h7)
    TX_COMPLETE_IRQ_ACK_I <= 1;
    cyc(1);
    TX_COMPLETE_IRQ_ACK_I <= 0;
    cyc(2);
    `CHK(TX_COMPLETE_IRQ_O, 1'b0)
    GLOBAL_IRQ_FLAG_I <= 0;
    cyc(2);
    `CHK({RX_COMPLETE_IRQ_O, BUFFER_EMPTY_IRQ_O}, 2'h0)
endtask
task automatic t_disable;
    wr(EN, 8'h18);
    wr(DA, 8'h77);
    wr(EN, 8'h10);
    `CHK(SERIAL_DATA_OUT_OE_O, 1'b1)
    wait_txc();
    cyc(2);
    `CHK(SERIAL_DATA_OUT_OE_O, 1'b0)
    rr(DA); #1 `CHK(rd, 32'hA5)
    wr(EN, 8'h00);
    rr(ST); #1 `CHK(rd[7], 1'b0)
    wr(MD, 8'hC1);
    cyc(2);
    `CHK(TRANSFER_CLOCK_O, 1'b1)
endtask
initial begin
    cyc(4);
    ARST_N_I <= 1;
    t_reset(); t_rx_only(); t_frame(); t_order(); t_irq(); t_disable();
    tally_and_finish();
end
endmodule
`default_nettype wire
